/* File: src/dither_pkg.sv */
// constants of the switching-frequency dither controller
// assumes one 100 MHz oscillator clock and a byte-wide register port
// What this block does
// - dead-band code 00/01/10/11 selects 180 mV, 350 mV, 700 mV, 1.4 V
// - dead-band register writes only land while in configuration mode
// - dithering varies the slope clock division by ramp or pseudo-random x
// - switching period equals nominal oscillator ratio plus current offset x
// - enable register: bits 0/2 dither enable, bits 1/3 ramp(0)/random(1)
// - bit 5 set: restart after temperature power-down once fault clears
// - bit 4 set: restart after battery UV/OV power-down once fault clears
// - scenario registers: width bits 7:6, scenario 5:4, phase enables 3:0
// - ramp, scenario 00/01: x sweeps 0 to 255/127/63/31 and back
// - ramp scenario 10: 0..-256>>w; scenario 11: -128..+127 scaled by width
// - random x drawn from the same ranges, scenario 10 is -128..-1 scaled
// - configuration-done bit 0 means configuration mode, 1 operation mode
package dither_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ADDR_FUNC_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_SCENARIO_G1  = 8'h0b;
  localparam logic [7:0] ADDR_SCENARIO_G2  = 8'h0c;
  localparam logic [7:0] ADDR_DITHER_CTRL  = 8'h1c;
  localparam logic [7:0] ADDR_DEADBAND_CFG = 8'h30;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_FUNC_CTRL     = 8'h00;
  localparam logic [7:0] RST_SCENARIO      = 8'h00;
  localparam logic [7:0] RST_DITHER_CTRL   = 8'h00;
  localparam logic [7:0] RST_DEADBAND_CFG  = 8'h09;
  // ==========================================================
  // field positions
  localparam int CONFIG_DONE_BIT  = 0;
  localparam int CH1_EN_BIT       = 0;
  localparam int CH1_RANDOM_BIT   = 1;
  localparam int CH2_EN_BIT       = 2;
  localparam int CH2_RANDOM_BIT   = 3;
  localparam int RESTART_VBAT_BIT = 4;
  localparam int RESTART_TEMP_BIT = 5;
  localparam int WIDTH_LSB        = 6;
  localparam int SCEN_LSB         = 4;
  localparam int PHASE_LSB        = 0;
  localparam int DEADBAND_LSB     = 4;
  // ==========================================================
  // scenario codes and generator constants
  typedef enum logic [1:0] {
    SCEN_POS_A = 2'b00,
    SCEN_POS_B = 2'b01,
    SCEN_NEG   = 2'b10,
    SCEN_BIP   = 2'b11
  } scen_t;
  localparam logic [15:0] LFSR_SEED_CH1  = 16'hace1;
  localparam logic [15:0] LFSR_SEED_CH2  = 16'h5a3f;
  localparam logic [15:0] LFSR_TAPS      = 16'hb400;
  localparam int          DEFAULT_RATIO  = 500;
  localparam int          X_W            = 10;
endpackage : dither_pkg

/* File: src/dither_ctrl.sv */
// dither controller: registers, offset generators, period counters
// assumes synchronous register strobes on the oscillator clock
`timescale 1ns/1ps
`default_nettype none
module dither_ctrl #(
  parameter int RATIO_W = 12
) (
  input  wire logic                 I_CLOCK,
  input  wire logic                 I_RESETN,
  input  wire logic                 i_reg_wr,
  input  wire logic                 i_reg_rd,
  input  wire logic [7:0]           i_reg_addr,
  input  wire logic [7:0]           i_reg_wdata,
  output logic      [7:0]           o_reg_rdata,
  input  wire logic [RATIO_W-1:0]   i_nominal_ratio,
  input  wire logic                 i_temp_fault,
  input  wire logic                 i_vbat_fault,
  output logic      [9:0]           o_ch1_dither_x,
  output logic      [9:0]           o_ch2_dither_x,
  output logic                      o_ch1_sw_tick,
  output logic                      o_ch2_sw_tick,
  output logic      [3:0]           o_group1_phase_en,
  output logic      [3:0]           o_group2_phase_en,
  output logic      [1:0]           o_deadband_code,
  output logic                      o_config_mode,
  output logic                      o_temp_power_down,
  output logic                      o_vbat_power_down
);
  localparam int PER_W = RATIO_W + 2;

  if (RATIO_W < 10 || RATIO_W > 20) begin : gen_bad_ratio
    $error("RATIO_W must lie between 10 and 20");
  end

  // ==========================================================
  // reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ==========================================================
  // register file
  logic [7:0] func_ctrl;
  logic [7:0] dither_scenario_group1;
  logic [7:0] dither_scenario_group2;
  logic [7:0] dither_enable_restart_ctrl;
  logic [7:0] regulation_deadband_cfg;

  wire config_done_lock = func_ctrl[dither_pkg::CONFIG_DONE_BIT];
  wire wr_func     = i_reg_wr && (i_reg_addr == dither_pkg::ADDR_FUNC_CTRL);
  wire wr_scen1    = i_reg_wr && (i_reg_addr == dither_pkg::ADDR_SCENARIO_G1);
  wire wr_scen2    = i_reg_wr && (i_reg_addr == dither_pkg::ADDR_SCENARIO_G2);
  wire wr_dctrl    = i_reg_wr && (i_reg_addr == dither_pkg::ADDR_DITHER_CTRL);
  wire wr_deadband = i_reg_wr && !config_done_lock
                     && (i_reg_addr == dither_pkg::ADDR_DEADBAND_CFG);

  wire [7:0] read_mux =
    (i_reg_addr == dither_pkg::ADDR_FUNC_CTRL)    ? func_ctrl :
    (i_reg_addr == dither_pkg::ADDR_SCENARIO_G1)  ? dither_scenario_group1 :
    (i_reg_addr == dither_pkg::ADDR_SCENARIO_G2)  ? dither_scenario_group2 :
    (i_reg_addr == dither_pkg::ADDR_DITHER_CTRL)  ? dither_enable_restart_ctrl :
    (i_reg_addr == dither_pkg::ADDR_DEADBAND_CFG) ? regulation_deadband_cfg :
    8'h00;

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      func_ctrl                  <= dither_pkg::RST_FUNC_CTRL;
      dither_scenario_group1     <= dither_pkg::RST_SCENARIO;
      dither_scenario_group2     <= dither_pkg::RST_SCENARIO;
      dither_enable_restart_ctrl <= dither_pkg::RST_DITHER_CTRL;
      regulation_deadband_cfg    <= dither_pkg::RST_DEADBAND_CFG;
      o_reg_rdata                <= 8'h00;
    end else begin
      if (wr_func)     func_ctrl                  <= i_reg_wdata;
      if (wr_scen1)    dither_scenario_group1     <= i_reg_wdata;
      if (wr_scen2)    dither_scenario_group2     <= i_reg_wdata;
      if (wr_dctrl)    dither_enable_restart_ctrl <= i_reg_wdata;
      if (wr_deadband) regulation_deadband_cfg    <= i_reg_wdata;
      if (i_reg_rd)    o_reg_rdata                <= read_mux;
    end
  end

  // ==========================================================
  // static outputs
  assign o_config_mode     = !config_done_lock;
  assign o_deadband_code   =
    regulation_deadband_cfg[dither_pkg::DEADBAND_LSB +: 2];
  assign o_group1_phase_en = dither_scenario_group1[dither_pkg::PHASE_LSB +: 4];
  assign o_group2_phase_en = dither_scenario_group2[dither_pkg::PHASE_LSB +: 4];

  // ==========================================================
  // restart after fault power-down
  wire restart_temp = dither_enable_restart_ctrl[dither_pkg::RESTART_TEMP_BIT];
  wire restart_vbat = dither_enable_restart_ctrl[dither_pkg::RESTART_VBAT_BIT];

  always_ff @(posedge I_CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      o_temp_power_down <= 1'b0;
      o_vbat_power_down <= 1'b0;
    end else begin
      if (i_temp_fault)      o_temp_power_down <= 1'b1;
      else if (restart_temp) o_temp_power_down <= 1'b0;
      if (i_vbat_fault)      o_vbat_power_down <= 1'b1;
      else if (restart_vbat) o_vbat_power_down <= 1'b0;
    end
  end

  // ==========================================================
  // per-channel offset generator and period counter
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    wire [7:0] scen_reg = (g == 0) ? dither_scenario_group1
                                   : dither_scenario_group2;
    wire [1:0] wcode = scen_reg[dither_pkg::WIDTH_LSB +: 2];
    wire [1:0] scode = scen_reg[dither_pkg::SCEN_LSB +: 2];
    wire en = dither_enable_restart_ctrl[(g == 0) ? dither_pkg::CH1_EN_BIT
                                                  : dither_pkg::CH2_EN_BIT];
    wire random_sel =
      dither_enable_restart_ctrl[(g == 0) ? dither_pkg::CH1_RANDOM_BIT
                                          : dither_pkg::CH2_RANDOM_BIT];

    logic signed [9:0]       x;
    logic                    dir_up;
    logic [15:0]             lfsr;
    logic [PER_W-1:0]        cnt;
    logic                    tick;

    // ramp bounds
    wire [7:0] top8  = 8'hff >> wcode;
    wire [6:0] half7 = 7'h7f >> wcode;
    wire signed [9:0] top  = $signed({2'b00, top8});
    wire signed [9:0] half = $signed({3'b000, half7});
    wire signed [9:0] lo =
      (scode == dither_pkg::SCEN_NEG) ? -(top + 10'sd1) :
      (scode == dither_pkg::SCEN_BIP) ? -(half + 10'sd1) :
      10'sd0;
    wire signed [9:0] hi =
      (scode == dither_pkg::SCEN_NEG) ? 10'sd0 :
      (scode == dither_pkg::SCEN_BIP) ? half :
      top;

    // random draw
    wire [7:0] u8 = lfsr[7:0] >> wcode;
    wire [6:0] u7 = lfsr[6:0] >> wcode;
    wire signed [9:0] rand_x =
      (scode == dither_pkg::SCEN_NEG) ? -10'sd1 - $signed({3'b000, u7}) :
      (scode == dither_pkg::SCEN_BIP) ? $signed({2'b00, u8}) - (half + 10'sd1) :
      $signed({2'b00, u8});

    wire signed [9:0] ramp_next =
      dir_up ? ((x >= hi) ? x - 10'sd1 : x + 10'sd1)
             : ((x <= lo) ? x + 10'sd1 : x - 10'sd1);
    wire next_dir_up = dir_up ? (x < hi) : (x <= lo);

    // period = nominal ratio + x, never below one cycle
    wire signed [PER_W-1:0] period =
      $signed({2'b00, i_nominal_ratio})
      + $signed({{(PER_W-10){x[9]}}, x});
    wire [PER_W-1:0] period_m1 =
      (period <= $signed(PER_W'(1))) ? '0 : PER_W'(period - PER_W'(1));
    assign tick = (cnt >= period_m1);

    always_ff @(posedge I_CLOCK or negedge rst_n) begin
      if (!rst_n) begin
        x      <= 10'sd0;
        dir_up <= 1'b1;
        lfsr   <= (g == 0) ? dither_pkg::LFSR_SEED_CH1
                           : dither_pkg::LFSR_SEED_CH2;
        cnt    <= '0;
      end else begin
        cnt <= tick ? '0 : cnt + PER_W'(1);
        if (tick) begin
          lfsr <= lfsr[0] ? ((lfsr >> 1) ^ dither_pkg::LFSR_TAPS) : lfsr >> 1;
          if (!en) begin
            x      <= 10'sd0;
            dir_up <= 1'b1;
          end else if (random_sel) begin
            x <= rand_x;
          end else begin
            x      <= ramp_next;
            dir_up <= next_dir_up;
          end
        end
      end
    end
  end

  assign o_ch1_dither_x = gen_ch[0].x;
  assign o_ch2_dither_x = gen_ch[1].x;
  assign o_ch1_sw_tick  = gen_ch[0].tick;
  assign o_ch2_sw_tick  = gen_ch[1].tick;
endmodule : dither_ctrl
`default_nettype wire

/* File: bench/dither_ctrl_props.sv */
// checker on the dither controller top ports
// assumes a bind onto dither_ctrl, one clock domain
`timescale 1ns/1ps
`default_nettype none
module dither_ctrl_props #(parameter int RATIO_W = 12) (
  input wire logic               I_CLOCK,
  input wire logic               I_RESETN,
  input wire logic               i_reg_wr,
  input wire logic               i_temp_fault,
  input wire logic               i_vbat_fault,
  input wire logic               o_ch1_sw_tick,
  input wire logic               o_config_mode,
  input wire logic               o_temp_power_down,
  input wire logic               o_vbat_power_down,
  input wire logic [7:0]         i_reg_addr,
  input wire logic [7:0]         i_reg_wdata,
  input wire logic [RATIO_W-1:0] i_nominal_ratio,
  input wire logic [9:0]         o_ch1_dither_x,
  input wire logic [1:0]         o_deadband_code
);
  logic [2:0] ok;
  logic [21:0] cnt;
  logic seen;
  wire signed [21:0] per = $signed({1'b0, i_nominal_ratio})
    + $signed(o_ch1_dither_x);
  always_ff @(posedge I_CLOCK or negedge I_RESETN)
    if (!I_RESETN) {ok, cnt, seen} <= '0;
    else {ok, cnt, seen} <= {ok[1:0], 1'b1,
      o_ch1_sw_tick ? 22'h0 : cnt + 22'h1, seen | (o_ch1_sw_tick & ok[2])};
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!ok[2]);
  a_temp_latch: assert property (i_temp_fault |=> o_temp_power_down)
    else $error("temp fault not latched");
  a_temp_clear: assert property ($fell(o_temp_power_down) |->
    !$past(i_temp_fault)) else $error("temp latch left early");
  a_vbat_latch: assert property (i_vbat_fault |=> o_vbat_power_down)
    else $error("vbat fault not latched");
  a_vbat_clear: assert property ($fell(o_vbat_power_down) |->
    !$past(i_vbat_fault)) else $error("vbat latch left early");
  a_band_locked: assert property (!o_config_mode |=>
    $stable(o_deadband_code)) else $error("dead-band moved while locked");
  a_mode_write: assert property (i_reg_wr && i_reg_addr == 8'h00 |=>
    o_config_mode == !$past(i_reg_wdata[0])) else $error("mode bit wrong");
  a_x_stands: assert property (!o_ch1_sw_tick |=>
    $stable(o_ch1_dither_x)) else $error("offset moved mid period");
  a_period_len: assert property (o_ch1_sw_tick && seen |->
    cnt + 22'h1 == (per < 2 ? 22'h1 : 22'(per))) else $error("period wrong");
  c_tick: cover property (o_ch1_sw_tick && seen);
  c_restart: cover property ($fell(o_temp_power_down));
  c_locked_write: cover property (!o_config_mode && i_reg_wr);
endmodule : dither_ctrl_props
bind dither_ctrl dither_ctrl_props #(.RATIO_W(RATIO_W)) u_props (.*);
`default_nettype wire

/* File: bench/tb.sv */
// bench for the dither controller: registers, ramp, random, faults
// assumes dither_ctrl and its bound checker compiled beforehand
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("mismatch %0t got %h exp %h", $time, a, e); end end
`define STEP @(posedge I_CLOCK) #1;
module tb;
  logic I_CLOCK = '0, I_RESETN = '0, i_reg_wr = '0, i_reg_rd = '0;
  logic i_temp_fault = '0, i_vbat_fault = '0, o_ch1_sw_tick, o_ch2_sw_tick;
  logic o_config_mode, o_temp_power_down, o_vbat_power_down;
  logic [7:0] i_reg_addr = '0, i_reg_wdata = '0, o_reg_rdata;
  logic [11:0] i_nominal_ratio = 12'h028;
  logic [9:0] o_ch1_dither_x, o_ch2_dither_x;
  logic [3:0] o_group1_phase_en, o_group2_phase_en;
  logic [1:0] o_deadband_code;
  int mismatches = 0, compares = 0;
  dither_ctrl #(.RATIO_W(12)) u_dither_ctrl (.*);
  always #5 I_CLOCK = ~I_CLOCK;
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  // one register cycle, a quiet cycle, then read data is judged
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} = {a, d, w, !w};
    `STEP
    {i_reg_wr, i_reg_rd} = 2'b00;
    `STEP
    if (!w) `CHK(o_reg_rdata, d)
  endtask : acc
  // waits for a period tick, then lets the new offset land
  task automatic wt(logic c);
    for (int n = 0; (c ? o_ch2_sw_tick : o_ch1_sw_tick) !== 1'b1; n++)
      if (n < 4096) `STEP else begin mismatches++; stop_test(); end
    `STEP
  endtask : wt
  task automatic t_regs();
    logic [7:0] a[6] = '{8'h00, 8'h0b, 8'h0c, 8'h1c, 8'h30, 8'h01};
    for (int i = 0; i < 6; i++) acc(1'b0, a[i], (i == 4) ? 8'h09 : 8'h00);
    for (int c = 0; c < 4; c++) begin
      acc(1'b1, 8'h30, {2'b00, 2'(c), 4'h9});
      `CHK(o_deadband_code, 2'(c))
      `CHK(o_config_mode, 1'b1)
    end
    acc(1'b1, 8'h00, 8'h01);
    acc(1'b1, 8'h30, 8'h09);
    `CHK({o_config_mode, o_deadband_code}, 3'b011)
    acc(1'b0, 8'h30, 8'h39);
  endtask : t_regs
  // enables one channel just after its tick, then follows the triangle
  task automatic ramp_run(logic c, logic [7:0] en, int lo, int hi);
    int e = 0, d = 1;
    wt(c);
    acc(1'b1, 8'h1c, en);
    for (int i = 0; i < 70; i++) begin
      d = (e + d > hi || e + d < lo) ? -d : d;
      e = e + d;
      wt(c);
      `CHK(c ? o_ch2_dither_x : o_ch1_dither_x, 10'(e))
    end
  endtask : ramp_run
  task automatic t_ramp();
    acc(1'b1, 8'h0b, 8'hf5);
    acc(1'b1, 8'h0c, 8'hea);
    `CHK({o_group1_phase_en, o_group2_phase_en}, 8'h5a)
    ramp_run(1'b0, 8'h01, -16, 15);
    ramp_run(1'b1, 8'h04, -32, 0);
    acc(1'b1, 8'h0b, 8'hc5);
    ramp_run(1'b0, 8'h01, 0, 31);
  endtask : t_ramp
  task automatic t_random();
    acc(1'b1, 8'h1c, 8'h0f);
    repeat (20) begin
      wt(1'b1);
      `CHK($signed(o_ch2_dither_x) inside {[-16:-1]}, 1'b1)
      wt(1'b0);
      `CHK(o_ch1_dither_x <= 10'd31, 1'b1)
    end
    acc(1'b1, 8'h0b, 8'hf5);
    wt(1'b0);
    repeat (20) begin
      wt(1'b0);
      `CHK($signed(o_ch1_dither_x) inside {[-16:15]}, 1'b1)
    end
  endtask : t_random
  task automatic t_fault();
    acc(1'b1, 8'h1c, 8'h20);
    {i_temp_fault, i_vbat_fault} = 2'b11;
    repeat (2) `STEP
    `CHK({o_temp_power_down, o_vbat_power_down}, 2'b11)
    {i_temp_fault, i_vbat_fault} = 2'b00;
    repeat (2) `STEP
    `CHK({o_temp_power_down, o_vbat_power_down}, 2'b01)
    acc(1'b1, 8'h1c, 8'h10);
    `CHK(o_vbat_power_down, 1'b0)
  endtask : t_fault
  initial begin
    repeat (4) `STEP
    I_RESETN = 1'b1;
    repeat (3) `STEP
    t_regs();
    t_ramp();
    t_random();
    t_fault();
    stop_test();
  end
endmodule : tb
`default_nettype wire
